// [pkg/e4f_consts.vh]
// constants for the bus framing supervision and link status block
`ifndef E4F_CONSTS_VH
`define E4F_CONSTS_VH

// ****************************************************************
// timing
// ****************************************************************
`define E4F_CLK_PERIOD_PS    4000
`define E4F_RECOVERY_TIME_US 1000
`define E4F_JAM_TIME_NS      8000
`define E4F_JAM_CYCLES       ((`E4F_JAM_TIME_NS * 1000 + `E4F_CLK_PERIOD_PS - 1) / `E4F_CLK_PERIOD_PS)
`define E4F_RECOVERY_CYCLES  ((`E4F_RECOVERY_TIME_US * 1000000) / `E4F_CLK_PERIOD_PS)
`define E4F_JAM_CNT_W        12
`define E4F_TMR_W            20

// ****************************************************************
// register map (byte addresses)
// ****************************************************************
`define E4F_ADDR_W        4
`define E4F_REG_CTRL      4'h0
`define E4F_REG_STATUS    4'h4
`define E4F_REG_IRQ_STAT  4'h8
`define E4F_REG_IRQ_MASK  4'hC

// control fields
`define E4F_CTRL_FORCED_DOWN 0
`define E4F_CTRL_HOB_CAPABLE 1
`define E4F_CTRL_RESET       2'h0

// status fields
`define E4F_ST_STATE_LSB  0
`define E4F_ST_STATE_MSB  3
`define E4F_ST_PH_UP      4
`define E4F_ST_MGMT_VALID 5
`define E4F_ST_TX_FRAMED  6
`define E4F_ST_JAM_SEEN   7
`define E4F_ST_LSS_LSB    8
`define E4F_ST_LSS_MSB    9
`define E4F_ST_INLSS_LSB  10
`define E4F_ST_INLSS_MSB  11
`define E4F_ST_OTHER_LSB  12
`define E4F_ST_OTHER_MSB  15

// interrupt events
`define E4F_IRQ_W        4
`define E4F_IRQ_IN_FRAME 0
`define E4F_IRQ_OOF      1
`define E4F_IRQ_LOF      2
`define E4F_IRQ_JAM      3
`define E4F_IRQ_RESET    4'h0

// link status codes
`define E4F_LSS_CONNECTED  2'h0
`define E4F_LSS_RX_LINK_UP 2'h1
`define E4F_LSS_HOB_INCAP  2'h2
`define E4F_LSS_RX_LINK_DN 2'h3

// one-hot framing states
`define E4F_ST_IN_FRAME 4'h1
`define E4F_ST_OOF      4'h2
`define E4F_ST_OOF_JAM  4'h4
`define E4F_ST_LOF      4'h8

// jam pattern phase
`define E4F_JAM_PHASE_W    2
`define E4F_JAM_PHASE_INIT 2'h0
`define E4F_JAM_ONES_END   2'h1

`endif

// [hw/e4f_recovery_timer.v]
// out-of-frame recovery timer: start/restart, stop, one-cycle expiry
`timescale 1ns/1ps
`include "e4f_consts.vh"
module e4f_recovery_timer #(
	parameter [`E4F_TMR_W-1:0] CYCLES = `E4F_RECOVERY_CYCLES
) (
	// clock and reset
	input  wire                  clock,
	input  wire                  srst,
	// control
	input  wire                  start,
	input  wire                  stop,
	// result
	output reg                   expired
);
	reg [`E4F_TMR_W-1:0] count;
	reg                  running;

	always @(posedge clock) begin
		if (srst) begin
			count   <= {`E4F_TMR_W{1'b0}};
			running <= 1'b0;
			expired <= 1'b0;
		end else begin
			expired <= 1'b0;
			if (start) begin
				count   <= CYCLES - 1'b1;
				running <= 1'b1;
			end else if (stop) begin
				running <= 1'b0;
			end else if (running) begin
				if (count == {`E4F_TMR_W{1'b0}}) begin
					running <= 1'b0;
					expired <= 1'b1;
				end else begin
					count <= count - 1'b1;
				end
			end
		end
	end
endmodule // e4f_recovery_timer

// [hw/e4f_jam_gen.v]
// serial jam pattern source: repeating 1100, restarting on sync
`timescale 1ns/1ps
`include "e4f_consts.vh"
module e4f_jam_gen (
	// clock and reset
	input  wire clock,
	input  wire srst,
	// bit timing
	input  wire bitStrobe,
	input  wire syncMark,
	// pattern
	output reg  jamBit
);
	reg [`E4F_JAM_PHASE_W-1:0] phase;

	always @(posedge clock) begin
		if (srst) begin
			phase  <= `E4F_JAM_PHASE_INIT;
			jamBit <= 1'b1;
		end else if (syncMark) begin
			phase  <= `E4F_JAM_PHASE_INIT;
			jamBit <= 1'b1;
		end else if (bitStrobe) begin
			// phases 0,1 carry ones, 2,3 carry zeros
			jamBit <= (phase <= `E4F_JAM_ONES_END);
			phase  <= phase + 1'b1;
		end
	end
endmodule // e4f_jam_gen

// [hw/e4f_framing_link.v]
// receive framing supervision and link status control for one bus
// Contract
// - in frame, framing, identifier and overhead octets and stuffing run normally
// - every entry into in-frame starts the outgoing frame with the framing pair
// - management indications invalid after in-frame entry until final overhead row
// - both framing octets errored or two bad identifiers leave in-frame, start timer
// - in frame, normal: connected or up gives UP/connected; down gives DOWN/up
// - out-of-frame keeps status, sends up; loss sends down, or up on jam
// - forced down reports DOWN and sends rx_link_dn in every case
// - capable flag clear and rx_link_dn received on that bus: send rx_link_dn
// - jam when out-of-frame without head role, or lost without role nor capability
// - framed signal when out-of-frame with role and capable, or lost and capable
// - frame selection uses both buses, timing source, head role, capable flag; here it uses only head role and capable flag
// - recovery timer runs 1 ms; expiry before framing means loss-of-frame
// - jam is repeating 1100, restarting with ones after each sync double octet
// - jam seen 8 us while out-of-frame enters jam state and restarts timer
// - from loss, two good pairs with sequential identifiers enter in-frame, UP
//
// Added by the designer: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`include "e4f_consts.vh"
module e4f_framing_link #(
	parameter [`E4F_TMR_W-1:0] RECOVERY_CYCLES = `E4F_RECOVERY_CYCLES
) (
	// clock and reset
	input  wire        clock,
	input  wire        srst,
	// wishbone slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [3:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	// receive framing events
	input  wire        pairStrobe,
	input  wire        firstOctetErr,
	input  wire        secondOctetErr,
	input  wire        rowIdStrobe,
	input  wire        rowIdGood,
	input  wire        finalRowSeen,
	input  wire        jamDetect,
	input  wire [1:0]  incomingLss,
	input  wire [1:0]  farLssIn,
	// upper layer and other receiver
	input  wire        headRoleThisBus,
	input  wire        timingExternal,
	input  wire [3:0]  otherBusState,
	// transmit side
	input  wire        txBitStrobe,
	input  wire        txSyncMark,
	output reg         txFramed,
	output reg         txTimingExternal,
	output reg         txFrameStart,
	output reg         txJamBit,
	output reg  [1:0]  outgoingLss,
	output reg         stuffEnable,
	// indications upward
	output reg         phStatusUp,
	output reg         dataValid,
	output reg         mgmtValid,
	output reg         irq
);
	// ****************************************************************
	// registers
	// ****************************************************************
	reg [3:0]              state;
	reg [3:0]              next_state;
	reg                    forcedDown;
	reg                    hobCapable;
	reg [`E4F_IRQ_W-1:0]   irqStatus;
	reg [`E4F_IRQ_W-1:0]   irqMask;
	reg                    pairRun;
	reg                    idRun;
	reg                    badIdRun;
	reg [`E4F_JAM_CNT_W-1:0] jamCount;
	reg                    jamSeen;
	reg                    jamSeenLast;
	reg                    next_phUp;
	reg [1:0]              next_lss;
	reg                    next_framed;
	wire                   timerExpired;
	wire                   jamPattern;

	// ****************************************************************
	// helpers
	// ****************************************************************
	function outOfFrame;
		input [3:0] s;
		begin
			outOfFrame = (s == `E4F_ST_OOF) || (s == `E4F_ST_OOF_JAM);
		end
	endfunction

	function [31:0] zeroExtend16;
		input [15:0] v;
		begin
			zeroExtend16 = {16'h0000, v};
		end
	endfunction

	wire busWrite = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
	wire busRead  = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
	wire pairBad  = pairStrobe && firstOctetErr && secondOctetErr;
	wire pairGood = pairStrobe && !firstOctetErr && !secondOctetErr;
	wire idGood   = rowIdStrobe && rowIdGood;
	wire idBad    = rowIdStrobe && !rowIdGood;
	// a pair counts toward recovery only when its identifier is good too
	wire recoverStep = pairGood && idGood;
	wire loseFrame   = pairBad || (idBad && badIdRun);
	wire jamLong     = (jamCount == `E4F_JAM_CYCLES - 1) && jamDetect;

	// ****************************************************************
	// framing state machine
	// ****************************************************************
	always @* begin
		next_state = state;
		case (state)
			`E4F_ST_IN_FRAME: begin
				if (loseFrame)
					next_state = `E4F_ST_OOF;
			end
			`E4F_ST_OOF: begin
				if (recoverStep && pairRun && idRun)
					next_state = `E4F_ST_IN_FRAME;
				else if (timerExpired)
					next_state = `E4F_ST_LOF;
				else if (jamLong)
					next_state = `E4F_ST_OOF_JAM;
			end
			`E4F_ST_OOF_JAM: begin
				// one good pair suffices here
				if (recoverStep)
					next_state = `E4F_ST_IN_FRAME;
				else if (timerExpired)
					next_state = `E4F_ST_LOF;
			end
			`E4F_ST_LOF: begin
				if (recoverStep && pairRun && idRun)
					next_state = `E4F_ST_IN_FRAME;
			end
			default: next_state = `E4F_ST_LOF;
		endcase
	end

	wire enterInFrame = (next_state == `E4F_ST_IN_FRAME) &&
		(state != `E4F_ST_IN_FRAME);
	wire enterOof = (next_state == `E4F_ST_OOF) && (state != `E4F_ST_OOF);
	wire enterJam = (next_state == `E4F_ST_OOF_JAM) &&
		(state != `E4F_ST_OOF_JAM);
	wire enterLof = (next_state == `E4F_ST_LOF) && (state != `E4F_ST_LOF);

	always @(posedge clock) begin
		if (srst) begin
			state    <= `E4F_ST_LOF;
			pairRun  <= 1'b0;
			idRun    <= 1'b0;
			badIdRun <= 1'b0;
		end else begin
			state <= next_state;
			if (pairStrobe)
				pairRun <= pairGood && !enterInFrame;
			if (rowIdStrobe) begin
				idRun    <= idGood && !enterInFrame;
				badIdRun <= idBad && !loseFrame;
			end
		end
	end

	// ****************************************************************
	// jam detection and recovery timer
	// ****************************************************************
	always @(posedge clock) begin
		if (srst) begin
			jamCount    <= {`E4F_JAM_CNT_W{1'b0}};
			jamSeen     <= 1'b0;
			jamSeenLast <= 1'b0;
		end else begin
			jamSeenLast <= jamSeen;
			if (!jamDetect) begin
				jamCount <= {`E4F_JAM_CNT_W{1'b0}};
				jamSeen  <= 1'b0;
			end else if (jamLong || jamSeen) begin
				jamSeen <= 1'b1;
			end else begin
				jamCount <= jamCount + 1'b1;
			end
		end
	end

	e4f_recovery_timer #(
		.CYCLES (RECOVERY_CYCLES)
	) u_timer (
		.clock   (clock),
		.srst    (srst),
		.start   (enterOof || enterJam),
		.stop    (enterInFrame || enterLof),
		.expired (timerExpired)
	);

	e4f_jam_gen u_jam (
		.clock     (clock),
		.srst      (srst),
		.bitStrobe (txBitStrobe),
		.syncMark  (txSyncMark),
		.jamBit    (jamPattern)
	);

	// ****************************************************************
	// link status and frame selection
	// ****************************************************************
	always @* begin
		next_phUp = phStatusUp;
		next_lss  = `E4F_LSS_RX_LINK_UP;
		if (forcedDown) begin
			next_phUp = 1'b0;
			next_lss  = `E4F_LSS_RX_LINK_DN;
		end else begin
			case (next_state)
				`E4F_ST_IN_FRAME: begin
					if (incomingLss == `E4F_LSS_RX_LINK_DN) begin
						next_phUp = 1'b0;
						next_lss  = `E4F_LSS_RX_LINK_UP;
					end else if (incomingLss == `E4F_LSS_HOB_INCAP) begin
						next_lss  = `E4F_LSS_CONNECTED;
					end else begin
						next_phUp = 1'b1;
						next_lss  = `E4F_LSS_CONNECTED;
					end
				end
				`E4F_ST_OOF, `E4F_ST_OOF_JAM: begin
					next_lss = `E4F_LSS_RX_LINK_UP;
				end
				`E4F_ST_LOF: begin
					next_phUp = 1'b0;
					next_lss  = jamSeen ? `E4F_LSS_RX_LINK_UP :
						`E4F_LSS_RX_LINK_DN;
				end
				default: begin
					next_phUp = 1'b0;
					next_lss  = `E4F_LSS_RX_LINK_DN;
				end
			endcase
			// an isolated incapable node echoes the failure back
			if (!hobCapable && farLssIn == `E4F_LSS_RX_LINK_DN)
				next_lss = `E4F_LSS_RX_LINK_DN;
		end
	end

	always @* begin
		next_framed = 1'b1;
		if (outOfFrame(next_state))
			next_framed = headRoleThisBus && hobCapable;
		else if (next_state == `E4F_ST_LOF)
			next_framed = hobCapable;
	end

	always @(posedge clock) begin
		if (srst) begin
			phStatusUp       <= 1'b0;
			outgoingLss      <= `E4F_LSS_RX_LINK_DN;
			txFramed         <= 1'b0;
			txTimingExternal <= 1'b0;
			txFrameStart     <= 1'b0;
			txJamBit         <= 1'b1;
			stuffEnable      <= 1'b0;
			dataValid        <= 1'b0;
			mgmtValid        <= 1'b0;
		end else begin
			phStatusUp  <= next_phUp;
			outgoingLss <= next_lss;
			txFramed    <= next_framed;
			// timing source only matters when this node times the bus
			txTimingExternal <= timingExternal &&
				(next_state != `E4F_ST_IN_FRAME);
			// restart the outgoing frame at the framing pair
			txFrameStart <= enterInFrame ||
				(enterLof && hobCapable);
			txJamBit    <= jamPattern;
			stuffEnable <= (next_state == `E4F_ST_IN_FRAME) || next_framed;
			dataValid   <= (next_state == `E4F_ST_IN_FRAME);
			if (next_state != `E4F_ST_IN_FRAME || enterInFrame)
				mgmtValid <= 1'b0;
			else if (finalRowSeen)
				mgmtValid <= 1'b1;
		end
	end

	// ****************************************************************
	// wishbone register file and interrupt
	// ****************************************************************
	wire [`E4F_IRQ_W-1:0] irqEvent;
	assign irqEvent[`E4F_IRQ_IN_FRAME] = enterInFrame;
	assign irqEvent[`E4F_IRQ_OOF]      = enterOof;
	assign irqEvent[`E4F_IRQ_LOF]      = enterLof;
	assign irqEvent[`E4F_IRQ_JAM]      = jamSeen && !jamSeenLast;

	wire [15:0] statusWord = {otherBusState, incomingLss, outgoingLss,
		jamSeen, txFramed, mgmtValid, phStatusUp, state};

	always @(posedge clock) begin
		if (srst) begin
			wb_ack_o   <= 1'b0;
			wb_dat_o   <= 32'h00000000;
			forcedDown <= 1'b0;
			hobCapable <= 1'b0;
			irqStatus  <= `E4F_IRQ_RESET;
			irqMask    <= `E4F_IRQ_RESET;
			irq        <= 1'b0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			wb_dat_o <= 32'h00000000;
			if (busRead) begin
				case (wb_adr_i)
					`E4F_REG_CTRL:
						wb_dat_o <= {30'h0000000, hobCapable, forcedDown};
					`E4F_REG_STATUS:
						wb_dat_o <= zeroExtend16(statusWord);
					`E4F_REG_IRQ_STAT:
						wb_dat_o <= {28'h0000000, irqStatus};
					`E4F_REG_IRQ_MASK:
						wb_dat_o <= {28'h0000000, irqMask};
					default:
						wb_dat_o <= 32'h00000000;
				endcase
			end
			if (busWrite && wb_sel_i[0] && wb_adr_i == `E4F_REG_CTRL) begin
				forcedDown <= wb_dat_i[`E4F_CTRL_FORCED_DOWN];
				hobCapable <= wb_dat_i[`E4F_CTRL_HOB_CAPABLE];
			end
			if (busWrite && wb_sel_i[0] && wb_adr_i == `E4F_REG_IRQ_MASK)
				irqMask <= wb_dat_i[`E4F_IRQ_W-1:0];
			// set wins over a write-one clear in the same cycle
			if (busWrite && wb_sel_i[0] && wb_adr_i == `E4F_REG_IRQ_STAT)
				irqStatus <= (irqStatus & ~wb_dat_i[`E4F_IRQ_W-1:0]) |
					irqEvent;
			else
				irqStatus <= irqStatus | irqEvent;
			irq <= |(irqStatus & irqMask);
		end
	end
endmodule // e4f_framing_link

// [dv/e4f_link_checker.sv]
// assertion checker for the framing link block
`timescale 1ns/1ps
module e4f_link_checker #(
	parameter [19:0] RECOVERY_CYCLES = 20'h0C00
) (
	// clock and reset
	input logic       clock,
	input logic       srst,
	// bus
	input logic       wb_cyc_i,
	input logic       wb_stb_i,
	input logic       wb_ack_o,
	// receive events
	input logic       pairStrobe,
	input logic       firstOctetErr,
	input logic       secondOctetErr,
	input logic       rowIdStrobe,
	input logic       rowIdGood,
	input logic       finalRowSeen,
	input logic       jamDetect,
	input logic [1:0] incomingLss,
	input logic       headRoleThisBus,
	// outputs
	input logic       txFramed,
	input logic       txFrameStart,
	input logic [1:0] outgoingLss,
	input logic       stuffEnable,
	input logic       phStatusUp,
	input logic       dataValid,
	input logic       mgmtValid
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);
	logic [19:0] oofCnt;
	// jam restarts the recovery timer, so the count restarts with it
	always @(posedge clock)
		if (srst || dataValid || jamDetect)
			oofCnt <= 20'h0;
		else if (oofCnt != 20'hFFFFF)
			oofCnt <= oofCnt + 20'h1;
	a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o) else $error("bus request not answered");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_stuff_in_frame: assert property (dataValid |-> stuffEnable)
		else $error("stuffing off while in frame");
	a_entry_start: assert property ($rose(dataValid) |-> txFrameStart)
		else $error("no framing pair at in-frame entry");
	a_mgmt_hold: assert property ($rose(dataValid) |-> !mgmtValid)
		else $error("management valid at entry");
	a_mgmt_cause: assert property ($rose(mgmtValid) |->
		$past(finalRowSeen) && dataValid) else $error("management valid early");
	a_pair_exit: assert property (dataValid && pairStrobe && firstOctetErr
		&& secondOctetErr |=> !dataValid) else $error("errored pair kept frame");
	a_entry_cause: assert property ($rose(dataValid) |-> $past(pairStrobe
		&& rowIdStrobe && rowIdGood && !firstOctetErr && !secondOctetErr))
		else $error("in-frame without good pair");
	a_inf_up: assert property (dataValid && !$past(incomingLss[1])
		&& outgoingLss != 2'h3 |-> outgoingLss == 2'h0 && phStatusUp)
		else $error("in frame link not up");
	a_inf_down: assert property (dataValid && $past(incomingLss) == 2'h3
		&& outgoingLss != 2'h3 |-> outgoingLss == 2'h1 && !phStatusUp)
		else $error("in frame link down mishandled");
	a_oof_keep: assert property ($fell(dataValid) |->
		phStatusUp == $past(phStatusUp)) else $error("status moved on exit");
	a_oof_jam: assert property ($fell(dataValid) && !$past(headRoleThisBus)
		|-> !txFramed) else $error("framed without head role");
	a_timer_loss: assert property (oofCnt == RECOVERY_CYCLES + 20'h1
		|-> outgoingLss == 2'h3 && !phStatusUp) else $error("timer missed");
	cover property ($rose(dataValid));
	cover property ($fell(dataValid) && headRoleThisBus);
	cover property (oofCnt == RECOVERY_CYCLES);
endmodule // e4f_link_checker

bind e4f_framing_link e4f_link_checker #(
	.RECOVERY_CYCLES(RECOVERY_CYCLES)
) e4f_link_checker_i (.*);

// [dv/e4f_peer_model.sv]
// far-side model: framing events and link status from the adjacent node
`timescale 1ns/1ps
module e4f_peer_model (
	// clock
	input  logic       clock,
	// framing events
	output logic       pairStrobe,
	output logic       firstOctetErr,
	output logic       secondOctetErr,
	output logic       rowIdStrobe,
	output logic       rowIdGood,
	output logic       finalRowSeen,
	// line state
	output logic       jamDetect,
	output logic [1:0] incomingLss,
	// transmit bit timing
	output logic       txBitStrobe,
	output logic       txSyncMark
);
	logic [5:0] bitCnt;
	initial begin
		{pairStrobe, rowIdStrobe, finalRowSeen, jamDetect} = 4'h0;
		{firstOctetErr, secondOctetErr, rowIdGood} = 3'h0;
		{txBitStrobe, txSyncMark} = 2'h0;
		incomingLss = 2'h0;
		bitCnt = 6'h0;
	end
	// a payload bit every other cycle, a sync mark once per 64
	always @(posedge clock) begin
		bitCnt <= bitCnt + 6'h1;
		txBitStrobe <= bitCnt[0];
		txSyncMark <= bitCnt == 6'h3F;
	end
	// qualifiers flip to their inverse once the strobes drop
	task send(input logic p, input logic b1, input logic b2,
		input logic r, input logic g);
		@(posedge clock);
		pairStrobe <= p;
		firstOctetErr <= b1;
		secondOctetErr <= b2;
		rowIdStrobe <= r;
		rowIdGood <= g;
		@(posedge clock);
		pairStrobe <= 1'b0;
		rowIdStrobe <= 1'b0;
		firstOctetErr <= !b1;
		secondOctetErr <= !b2;
		rowIdGood <= !g;
	endtask
	task overhead();
		@(posedge clock);
		finalRowSeen <= 1'b1;
		@(posedge clock);
		finalRowSeen <= 1'b0;
	endtask
	task setLine(input logic [1:0] l, input logic j);
		@(posedge clock);
		incomingLss <= l;
		jamDetect <= j;
	endtask
endmodule // e4f_peer_model

// [dv/e4f_framing_link_test.sv]
// self-checking testbench for the framing link block
`timescale 1ns/1ps
module e4f_framing_link_test;
	// ****************************************************************
	// signals
	// ****************************************************************
	localparam [19:0] RC = 20'h0C00;
	typedef struct packed {
		logic [1:0] inL;
		logic [1:0] far;
		logic [1:0] expL;
		logic       expUp;
	} e4f_lss_row;
	e4f_lss_row rows [5] = '{'{2'h1, 2'h0, 2'h0, 1'b1},
		'{2'h3, 2'h0, 2'h1, 1'b0}, '{2'h2, 2'h0, 2'h0, 1'b0},
		'{2'h0, 2'h0, 2'h0, 1'b1}, '{2'h0, 2'h3, 2'h3, 1'b1}};
	logic        clock = 1'b0;
	logic        srst = 1'b1;
	logic        wbCyc = 1'b0;
	logic        wbStb = 1'b0;
	logic        wbWe = 1'b0;
	logic [3:0]  wbAdr = 4'h0;
	logic [31:0] wbDat = 32'h0;
	logic [1:0]  farLss = 2'h0;
	logic        headRole = 1'b0;
	logic        timExt = 1'b1;
	wire         tmExt;
	logic [31:0] q;
	wire  [31:0] rdat;
	wire  [1:0]  inLss, outLss;
	wire         ack, pairS, err1, err2, rowS, rowG, fin, jam, bitS, syncM;
	wire         txFramed, frameStart, jamBit, stuff, phUp, dv, mv, irq;
	int          err_total = 0;
	int          check_count = 0;
	int          n;
	always #2 clock = ~clock;
	e4f_framing_link #(.RECOVERY_CYCLES(RC)) e4f_framing_link_i (
		.clock(clock), .srst(srst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
		.wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF),
		.wb_dat_i(wbDat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.pairStrobe(pairS), .firstOctetErr(err1), .secondOctetErr(err2),
		.rowIdStrobe(rowS), .rowIdGood(rowG), .finalRowSeen(fin),
		.jamDetect(jam), .incomingLss(inLss), .farLssIn(farLss),
		.headRoleThisBus(headRole), .timingExternal(timExt),
		.otherBusState(4'h1), .txBitStrobe(bitS), .txSyncMark(syncM),
		.txFramed(txFramed), .txTimingExternal(tmExt),
		.txFrameStart(frameStart),
		.txJamBit(jamBit), .outgoingLss(outLss), .stuffEnable(stuff),
		.phStatusUp(phUp), .dataValid(dv), .mgmtValid(mv), .irq(irq));
	e4f_peer_model e4f_peer_model_i (.clock(clock), .pairStrobe(pairS),
		.firstOctetErr(err1), .secondOctetErr(err2), .rowIdStrobe(rowS),
		.rowIdGood(rowG), .finalRowSeen(fin), .jamDetect(jam),
		.incomingLss(inLss), .txBitStrobe(bitS), .txSyncMark(syncM));
	// ****************************************************************
	// tasks
	// ****************************************************************
	task stop_test();
		$display("mismatches %0d of %0d checks", err_total, check_count);
		if (err_total == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
			err_total++;
		end
	endtask
	// ack and read data are taken at the rising edge that samples ack high
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] rq);
		int k;
		k = 0;
		@(posedge clock);
		{wbCyc, wbStb, wbWe, wbAdr, wbDat} <= {2'h3, w, a, d};
		@(posedge clock);
		while (ack !== 1'b1 && k < 20) begin
			@(posedge clock);
			k++;
		end
		rq = rdat;
		{wbCyc, wbStb} <= 2'h0;
		if (ack !== 1'b1) begin
			err_total++;
			stop_test();
		end
	endtask
	task rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] v;
		wb(1'b0, a, 32'h0, v);
		chk(v & m, e);
	endtask
	task recover();
		e4f_peer_model_i.send(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
		e4f_peer_model_i.send(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
		@(negedge clock);
	endtask
	task waitLoss();
		n = 0;
		while (outLss !== 2'h3 && n < RC + 200) begin
			@(negedge clock);
			n++;
		end
		chk({31'h0, n >= RC - 8 && n <= RC + 4}, 32'h1);
	endtask
	// line jam bits lag the generator's strobe by two edges
	task jamChk();
		int k;
		k = 0;
		@(posedge clock);
		while (syncM !== 1'b1 && k < 100) begin
			@(posedge clock);
			k++;
		end
		if (syncM !== 1'b1) begin
			err_total++;
			stop_test();
		end else begin
			@(posedge clock);
			for (k = 0; k < 8; k++) begin
				repeat (2) @(posedge clock);
				@(negedge clock);
				chk(jamBit, {31'h0, !k[1]});
			end
		end
	endtask
	initial begin
		repeat (30000) @(posedge clock);
		err_total++;
		stop_test();
	end
	// ****************************************************************
	// sequence
	// ****************************************************************
	initial begin
		repeat (12) @(posedge clock);
		srst <= 1'b0;
		@(negedge clock);
		chk({phUp, dv, txFramed, outLss}, 5'h03);
		rd(4'h0, 32'h3, 32'h0);
		rd(4'h4, 32'hFFFF, 32'h1308);
		rd(4'h1, 32'hFFFFFFFF, 32'h0);
		wb(1'b1, 4'hC, 32'hF, q);
		recover();
		chk({tmExt, phUp, dv, mv, stuff, txFramed, outLss}, 8'h6C);
		@(negedge clock);
		chk(irq, 1'b1);
		wb(1'b1, 4'h8, 32'h1, q);
		rd(4'h8, 32'hF, 32'h0);
		chk(irq, 1'b0);
		e4f_peer_model_i.overhead();
		@(negedge clock);
		chk(mv, 1'b1);
		foreach (rows[i]) begin
			e4f_peer_model_i.setLine(rows[i].inL, 1'b0);
			farLss <= rows[i].far;
			repeat (2) @(posedge clock);
			@(negedge clock);
			chk({phUp, outLss}, {rows[i].expUp, rows[i].expL});
		end
		@(posedge clock);
		farLss <= 2'h0;
		wb(1'b1, 4'h0, 32'h1, q);
		@(negedge clock);
		chk({phUp, dv, outLss}, 4'h7);
		wb(1'b1, 4'h0, 32'h2, q);
		@(negedge clock);
		chk({phUp, outLss}, 3'h4);
		e4f_peer_model_i.send(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
		@(negedge clock);
		chk({phUp, dv, txFramed, outLss}, 5'h11);
		rd(4'h4, 32'hF, 32'h2);
		waitLoss();
		@(negedge clock);
		chk({tmExt, phUp, txFramed, outLss}, 5'h17);
		e4f_peer_model_i.setLine(2'h0, 1'b1);
		// jam must stand a full detection interval before it counts
		repeat (2002) @(posedge clock);
		@(negedge clock);
		chk(outLss, 2'h1);
		e4f_peer_model_i.setLine(2'h0, 1'b0);
		headRole <= 1'b1;
		recover();
		e4f_peer_model_i.send(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
		@(negedge clock);
		chk(dv, 1'b1);
		e4f_peer_model_i.send(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
		@(negedge clock);
		chk({dv, txFramed}, 2'h1);
		e4f_peer_model_i.setLine(2'h0, 1'b1);
		repeat (2010) @(posedge clock);
		rd(4'h4, 32'hF, 32'h4);
		e4f_peer_model_i.setLine(2'h0, 1'b0);
		e4f_peer_model_i.send(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
		@(negedge clock);
		chk(dv, 1'b1);
		wb(1'b1, 4'h0, 32'h0, q);
		headRole <= 1'b0;
		e4f_peer_model_i.send(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
		waitLoss();
		@(negedge clock);
		chk({txFramed, outLss}, 3'h3);
		rd(4'h8, 32'hF, 32'hF);
		wb(1'b1, 4'hC, 32'h0, q);
		@(negedge clock);
		chk(irq, 1'b0);
		wb(1'b1, 4'hC, 32'h4, q);
		@(negedge clock);
		chk(irq, 1'b1);
		wb(1'b1, 4'h8, 32'hF, q);
		rd(4'h8, 32'hF, 32'h0);
		chk(irq, 1'b0);
		jamChk();
		stop_test();
	end
endmodule // e4f_framing_link_test
